// ===== dv/nas_alu_tb.sv
// Self-checking bench of the nibble ALU against a flag model.
// Assumes one-cycle results and operands valid with op_valid.
`timescale 1ns/100ps
`default_nettype none
module nas_alu_tb;
  import nas_pkg::*;
  // --------
  // Signals
  // --------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  nas_op_e op = NAS_OP_NOP;
  logic [3:0] gr_col = 4'h0;
  logic [6:0] mem_addr = 7'h00;
  logic [3:0] gr_rdata = 4'h0;
  logic [3:0] mem_rdata = 4'h0;
  logic [3:0] imm = 4'h0;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [3:0] wr_data;
  logic skip;
  logic [3:0] status_hi;
  logic [3:0] status_lo;
  int fails = 0;
  int checked = 0;
  logic m_z = 1'b0, m_c = 1'b0, m_k = 1'b0, m_d = 1'b0; // Model zero, carry, compare, decimal
  logic x_we = 1'b0, x_sk = 1'b0; // Expected pulses of the pending op
  logic [6:0] x_a;
  logic [3:0] x_d;

  // Core clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  nas_alu nas_alu_inst (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .op_valid(op_valid), .op(op), .gr_col(gr_col), .mem_addr(mem_addr),
    .gr_rdata(gr_rdata), .mem_rdata(mem_rdata), .imm(imm), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .skip(skip), .status_hi(status_hi),
    .status_lo(status_lo));

  // --------
  // Tasks
  // --------
  task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Outputs of the pending op; flags are compared after every op
  task automatic chk_out;
    chk("wr_en", {6'h0, x_we}, {6'h0, wr_en});
    if (x_we)
    begin
      chk("wr_addr", x_a, wr_addr);
      chk("wr_data", {3'h0, x_d}, {3'h0, wr_data});
    end
    chk("skip", {6'h0, x_sk}, {6'h0, skip});
    chk("status_hi", {3'h0, m_k, m_c, m_z, 1'b0}, {3'h0, status_hi});
    chk("status_lo", {6'h0, m_d}, {3'h0, status_lo});
  endtask : chk_out

  // Write-back; status addresses land in the flags, never on wr_en
  task automatic put(input logic [6:0] ta, input logic [3:0] r);
    if (ta == NAS_ADDR_STATUS_LO)
      m_d = r[0];
    else if (ta == NAS_ADDR_STATUS_HI)
      {m_k, m_c, m_z} = r[3:1];
    else
    begin
      x_we = 1'b1;
      x_a = ta;
      x_d = r;
    end
  endtask : put

  // Checks the previous op, drives the next one and predicts it
  task automatic issue(input nas_op_e o, input logic [3:0] col, input logic [6:0] ma,
    input logic [3:0] g, input logic [3:0] m, input logic [3:0] i,
    input logic v = 1'b1, input logic e = 1'b1);
    int a, b, r, ci;
    logic [3:0] mv;
    logic [6:0] ta;
    logic im, sb;
    @(negedge sys_clk);
    chk_out();
    op = o;
    {gr_col, mem_addr, gr_rdata, mem_rdata, imm} = {col, ma, g, m, i};
    op_valid = v;
    clk_en = e;
    // A frozen clock holds every output
    if (!e)
      return;
    {x_we, x_sk} = 2'b00;
    if (!v)
      return;
    mv = (ma == NAS_ADDR_STATUS_LO) ? {3'h0, m_d} :
         (ma == NAS_ADDR_STATUS_HI) ? {m_k, m_c, m_z, 1'b0} : m;
    im = o inside {NAS_OP_ADD_IM, NAS_OP_ADDC_IM, NAS_OP_SUB_IM, NAS_OP_SUBC_IM,
                   NAS_OP_OR_IM, NAS_OP_AND_IM, NAS_OP_XOR_IM};
    sb = o inside {NAS_OP_SUB_GR, NAS_OP_SUBC_GR, NAS_OP_SUB_IM, NAS_OP_SUBC_IM};
    ci = (o inside {NAS_OP_ADDC_GR, NAS_OP_ADDC_IM, NAS_OP_SUBC_GR, NAS_OP_SUBC_IM}) ?
         int'(m_c) : 0;
    a = im ? mv : g;
    b = im ? i : mv;
    ta = im ? ma : {NAS_GR_ROW, col};
    case (o)
      NAS_OP_NOP: ;
      NAS_OP_ROTATE_RIGHT:
      begin
        put(ta, {m_c, g[3:1]});
        m_c = g[0];
      end
      NAS_OP_MOVE_IM: put(ma, i);
      NAS_OP_OR_GR, NAS_OP_OR_IM: put(ta, 4'(a | b));
      NAS_OP_AND_GR, NAS_OP_AND_IM: put(ta, 4'(a & b));
      NAS_OP_XOR_GR, NAS_OP_XOR_IM: put(ta, 4'(a ^ b));
      NAS_OP_SKIP_BITS_SET, NAS_OP_SKIP_BITS_CLEAR:
      begin
        x_sk = (o == NAS_OP_SKIP_BITS_SET) ? ((mv & i) == i) : ((mv & i) == 4'h0);
        m_k = 1'b0;
      end
      NAS_OP_SKIP_EQUAL: x_sk = (mv == i);
      NAS_OP_SKIP_UNEQUAL: x_sk = (mv != i);
      NAS_OP_SKIP_NOT_LESS: x_sk = (mv >= i);
      NAS_OP_SKIP_LESS: x_sk = (mv < i);
      default:
      begin
        r = sb ? a - b - ci : a + b + ci;
        m_c = sb ? (r < 0) : (r > 15);
        // Decimal digits get the six-step correction
        if (m_d && !sb && r > 9)
        begin
          r = r + 6;
          m_c = 1'b1;
        end
        if (m_d && sb && r < 0)
          r = r - 6;
        r = r & 15;
        if (r != 0)
          m_z = 1'b0;
        else if (!m_k)
          m_z = 1'b1;
        if (!m_k)
          put(ta, 4'(r));
      end
    endcase
  endtask : issue

  task automatic do_reset(input logic e);
    @(negedge sys_clk);
    chk_out();
    {srst, clk_en, op_valid} = {1'b1, e, 1'b0};
    repeat (3) @(negedge sys_clk);
    {srst, clk_en} = 2'b01;
    {m_z, m_c, m_k, m_d, x_we, x_sk} = 6'h00;
    chk_out();
  endtask : do_reset

  task automatic endtest(input string n);
    $display("test %s done", n);
  endtask : endtest

  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    $display("ERROR watchdog expected end seen timeout");
    test_done();
  end

  // --------
  // Scenarios
  // --------
  initial
  begin
    nas_op_e o;
    logic [6:0] a;
    logic [3:0] g, m, i;
    void'($urandom(32'h538A3236));
    do_reset(1'b1);
    endtest("reset");
    issue(NAS_OP_ADD_IM, 4'h0, 7'h10, 4'h0, 4'h3, 4'h4);
    issue(NAS_OP_ADD_GR, 4'h5, 7'h11, 4'hF, 4'h1, 4'h0);
    issue(NAS_OP_ADDC_GR, 4'h5, 7'h11, 4'h1, 4'h1, 4'h0);
    issue(NAS_OP_SUB_IM, 4'h0, 7'h12, 4'h0, 4'h0, 4'h1);
    issue(NAS_OP_SUBC_IM, 4'h0, 7'h12, 4'h0, 4'h5, 4'h2);
    issue(NAS_OP_MOVE_IM, 4'h0, 7'h7E, 4'h0, 4'h0, 4'h1);
    issue(NAS_OP_ADD_IM, 4'h0, 7'h13, 4'h0, 4'h8, 4'h5);
    issue(NAS_OP_SUB_IM, 4'h0, 7'h13, 4'h0, 4'h2, 4'h5);
    issue(NAS_OP_MOVE_IM, 4'h0, 7'h7E, 4'h0, 4'h0, 4'h0);
    endtest("arith");
    issue(NAS_OP_MOVE_IM, 4'h0, 7'h7F, 4'h0, 4'h0, 4'hF);
    issue(NAS_OP_MOVE_IM, 4'h0, 7'h7E, 4'h0, 4'h0, 4'hF);
    issue(NAS_OP_AND_GR, 4'h2, 7'h7F, 4'hF, 4'h0, 4'h0);
    do_reset(1'b0);
    endtest("status");
    issue(NAS_OP_OR_IM, 4'h0, 7'h7F, 4'h0, 4'h0, 4'hA);
    issue(NAS_OP_SUB_IM, 4'h0, 7'h20, 4'h0, 4'h4, 4'h4);
    issue(NAS_OP_SUB_IM, 4'h0, 7'h21, 4'h0, 4'h5, 4'h6);
    issue(NAS_OP_SUB_IM, 4'h0, 7'h22, 4'h0, 4'h6, 4'h6);
    issue(NAS_OP_SKIP_BITS_SET, 4'h0, 7'h7F, 4'h0, 4'h0, 4'h2);
    issue(NAS_OP_SKIP_BITS_CLEAR, 4'h0, 7'h7F, 4'h0, 4'h0, 4'h8);
    endtest("accumulate");
    issue(NAS_OP_ROTATE_RIGHT, 4'h3, 7'h00, 4'h8, 4'h0, 4'h0);
    issue(NAS_OP_ROTATE_RIGHT, 4'h3, 7'h00, 4'h3, 4'h0, 4'h0);
    for (int k = NAS_OP_SKIP_EQUAL; k <= NAS_OP_SKIP_LESS; k++)
      for (int n = 4; n < 7; n++)
        issue(nas_op_e'(k), 4'h0, 7'h30, 4'h0, 4'h5, 4'(n));
    endtest("compare");
    issue(NAS_OP_ADD_IM, 4'h0, 7'h10, 4'h0, 4'h1, 4'h1, 1'b1, 1'b0);
    issue(NAS_OP_ADD_IM, 4'h0, 7'h10, 4'h0, 4'h1, 4'h1, 1'b0);
    endtest("hold");
    // Status addresses only for ops that do not do arithmetic
    for (int n = 0; n < 300; n++)
    begin
      o = nas_op_e'($urandom_range(22, 1));
      a = 7'($urandom_range(125, 0));
      if (o >= NAS_OP_OR_GR && $urandom_range(3, 0) == 0)
        a = 7'h7E + 7'($urandom_range(1, 0));
      {g, m, i} = 12'($urandom);
      if (m_d)
        {g, m, i} = {4'(g % 10), 4'(m % 10), 4'(i % 10)};
      issue(o, 4'($urandom), a, g, m, i, $urandom_range(7, 0) != 0);
    end
    issue(NAS_OP_NOP, 4'h0, 7'h00, 4'h0, 4'h0, 4'h0, 1'b0);
    endtest("random");
    test_done();
  end
endmodule : nas_alu_tb
`default_nettype wire

// ===== hw/nas_adder.sv
// Binary and single-digit decimal adder/subtractor of the nibble ALU.
// Assumes operands are settled combinationally by the control module.
`timescale 1ns/100ps
`default_nettype none
module nas_adder
(
  nas_alu_if.arith alu
);
  import nas_pkg::*;

  // ----------------------------------------------------------------
  // Add or subtract with optional decimal correction
  // ----------------------------------------------------------------
  logic [4:0] raw; // Five-bit uncorrected result
  always_comb
  begin
    raw = 5'h00;
    alu.sum = NAS_NIBBLE_ZERO;
    alu.cout = 1'b0;
    if (alu.sub)
    begin
      // Borrow shows as bit 4 of the wrapped difference
      raw = {1'b0, alu.opa} - {1'b0, alu.opb} - {4'h0, alu.cin};
      alu.cout = raw[4];
      alu.sum = (alu.dec && raw[4]) ? raw[3:0] - NAS_BCD_ADJ : raw[3:0];
    end
    else
    begin
      raw = {1'b0, alu.opa} + {1'b0, alu.opb} + {4'h0, alu.cin};
      // Digits beyond nine wrap by adding six, which also raises carry
      if (alu.dec && (raw > {1'b0, NAS_BCD_MAX}))
      begin
        alu.sum = raw[3:0] + NAS_BCD_ADJ;
        alu.cout = 1'b1;
      end
      else
      begin
        alu.sum = raw[3:0];
        alu.cout = raw[4];
      end
    end
  end

endmodule : nas_adder
`default_nettype wire

// ===== hw/nas_alu.sv
// Top of the nibble ALU: operand selection, status word and write-back.
// Assumes the core fetches both operands from data memory in the same
// cycle it presents op_valid, and that it applies wr_* to data memory.
`timescale 1ns/100ps
`default_nettype none
module nas_alu
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire nas_pkg::nas_op_e op,
  input wire logic [3:0] gr_col,
  input wire logic [6:0] mem_addr,
  input wire logic [3:0] gr_rdata,
  input wire logic [3:0] mem_rdata,
  input wire logic [3:0] imm,
  output logic wr_en,
  output logic [6:0] wr_addr,
  output logic [3:0] wr_data,
  output logic skip,
  output logic [3:0] status_hi,
  output logic [3:0] status_lo
);
  import nas_pkg::*;

  // ----------------------------------------------------------------
  // Status flip-flops
  // ----------------------------------------------------------------
  logic zero_flag_r;              // Zero flag
  logic carry_flag_r;             // Carry flag
  logic compare_accumulate_flag_r; // Compare-accumulate flag
  logic bcd_flag_r;               // Decimal-mode flag

  // ----------------------------------------------------------------
  // Decode and operand selection
  // ----------------------------------------------------------------
  logic go;             // Instruction executes this cycle
  logic gr_form;        // First operand is the general register
  logic arith;          // Add or subtract instruction
  logic logic_op;       // AND, OR or XOR instruction
  logic compare;        // Compare-and-skip instruction
  logic bit_test;       // Bit test instruction
  logic rotate;         // Rotate right through carry
  logic [3:0] mem_val;  // Memory operand, status nibbles substituted
  logic [6:0] gr_addr;  // Address of the general register nibble
  nas_alu_if alu ();

  assign go = op_valid && clk_en;
  assign arith = nas_is_arith(op);
  assign logic_op = nas_is_logic(op);
  assign compare = nas_is_compare(op);
  assign bit_test = nas_is_bit_test(op);
  assign rotate = (op == NAS_OP_ROTATE_RIGHT);
  assign gr_form = op inside {NAS_OP_ADD_GR, NAS_OP_ADDC_GR, NAS_OP_SUB_GR,
                              NAS_OP_SUBC_GR, NAS_OP_OR_GR, NAS_OP_AND_GR,
                              NAS_OP_XOR_GR, NAS_OP_ROTATE_RIGHT};
  assign gr_addr = {NAS_GR_ROW, gr_col};

  // Status word presented as two nibbles; unused bits tied low
  assign status_hi = {compare_accumulate_flag_r, carry_flag_r, zero_flag_r, 1'b0};
  assign status_lo = {3'h0, bcd_flag_r};

  // Reads of the status addresses see the flip-flops, not memory
  always_comb
  begin
    if (mem_addr == NAS_ADDR_STATUS_HI)
      mem_val = status_hi;
    else if (mem_addr == NAS_ADDR_STATUS_LO)
      mem_val = status_lo;
    else
      mem_val = mem_rdata;
  end

  // ----------------------------------------------------------------
  // Drive the shared units
  // ----------------------------------------------------------------
  always_comb
  begin
    // Register forms pair register with memory, others memory with immediate
    alu.opa = gr_form ? gr_rdata : mem_val;
    alu.opb = gr_form ? mem_val : imm;
    alu.sub = op inside {NAS_OP_SUB_GR, NAS_OP_SUBC_GR, NAS_OP_SUB_IM,
                         NAS_OP_SUBC_IM} || compare;
    // Carry-in only for the carry forms and for rotation
    alu.cin = (op inside {NAS_OP_ADDC_GR, NAS_OP_SUBC_GR, NAS_OP_ADDC_IM,
                          NAS_OP_SUBC_IM} || rotate) && carry_flag_r;
    // Comparisons are always binary so their borrow is a true ordering
    alu.dec = arith && bcd_flag_r;
    unique case (op)
      NAS_OP_AND_GR, NAS_OP_AND_IM: alu.lsel = 2'h1;
      NAS_OP_XOR_GR, NAS_OP_XOR_IM: alu.lsel = 2'h2;
      NAS_OP_ROTATE_RIGHT: alu.lsel = 2'h3;
      default: alu.lsel = 2'h0;
    endcase
  end

  nas_adder u_adder (
    .alu (alu)
  );

  nas_logic u_logic (
    .alu (alu)
  );

  // ----------------------------------------------------------------
  // Result, write-back target and skip decision
  // ----------------------------------------------------------------
  logic arith_zero;      // Adder result is zero
  logic bits_sel_set;    // All selected bits are one
  logic bits_sel_clear;  // All selected bits are zero
  logic skip_nxt;        // Skip next instruction
  logic wb_en;           // Result goes back to the first operand
  logic [6:0] wb_addr;   // Target of the result
  logic [3:0] wb_data;   // Result value
  logic st_wr;           // Write-back lands on the status word

  assign arith_zero = (alu.sum == NAS_NIBBLE_ZERO);
  assign bits_sel_set = ((mem_val & imm) == imm);
  assign bits_sel_clear = ((mem_val & imm) == NAS_NIBBLE_ZERO);

  always_comb
  begin
    skip_nxt = 1'b0;
    unique case (op)
      NAS_OP_SKIP_BITS_SET: skip_nxt = bits_sel_set;
      NAS_OP_SKIP_BITS_CLEAR: skip_nxt = bits_sel_clear;
      NAS_OP_SKIP_EQUAL: skip_nxt = arith_zero;
      NAS_OP_SKIP_UNEQUAL: skip_nxt = !arith_zero;
      NAS_OP_SKIP_NOT_LESS: skip_nxt = !alu.cout;
      NAS_OP_SKIP_LESS: skip_nxt = alu.cout;
      default: skip_nxt = 1'b0;
    endcase
  end

  always_comb
  begin
    // While accumulating a compare, subtraction must not damage the data
    wb_en = (arith && !compare_accumulate_flag_r) || logic_op || rotate
            || (op == NAS_OP_MOVE_IM);
    wb_addr = gr_form ? gr_addr : mem_addr;
    if (arith)
      wb_data = alu.sum;
    else if (logic_op || rotate)
      wb_data = alu.lres;
    else
      wb_data = imm;
  end

  assign st_wr = wb_en && ((wb_addr == NAS_ADDR_STATUS_HI) ||
                           (wb_addr == NAS_ADDR_STATUS_LO));

  // ----------------------------------------------------------------
  // Memory write port and skip pulse
  // ----------------------------------------------------------------
  // Status nibbles are held here, so those writes never reach memory
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_en <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= NAS_NIBBLE_ZERO;
      skip <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_en <= op_valid && wb_en && !st_wr;
      wr_addr <= wb_addr;
      wr_data <= wb_data;
      skip <= op_valid && skip_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Zero flag
  // ----------------------------------------------------------------
  // A direct write of the status nibble wins over the arithmetic effect
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      zero_flag_r <= NAS_FLAG_RST;
    else if (go && st_wr && wb_addr == NAS_ADDR_STATUS_HI)
      zero_flag_r <= wb_data[NAS_BIT_ZERO];
    else if (go && arith)
    begin
      if (!arith_zero)
        zero_flag_r <= 1'b0;
      else if (!compare_accumulate_flag_r)
        zero_flag_r <= 1'b1;
      // Otherwise the accumulated match result is kept
    end
  end

  // ----------------------------------------------------------------
  // Carry flag
  // ----------------------------------------------------------------
  // Comparisons share the subtractor but never touch carry
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      carry_flag_r <= NAS_FLAG_RST;
    else if (go && st_wr && wb_addr == NAS_ADDR_STATUS_HI)
      carry_flag_r <= wb_data[NAS_BIT_CARRY];
    else if (go && arith)
      carry_flag_r <= alu.cout;
    else if (go && rotate)
      carry_flag_r <= alu.lcout;
  end

  // ----------------------------------------------------------------
  // Compare-accumulate flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      compare_accumulate_flag_r <= NAS_FLAG_RST;
    else if (go && bit_test)
      compare_accumulate_flag_r <= 1'b0;
    else if (go && st_wr && wb_addr == NAS_ADDR_STATUS_HI)
      compare_accumulate_flag_r <= wb_data[NAS_BIT_COMPARE];
  end

  // ----------------------------------------------------------------
  // Decimal-mode flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bcd_flag_r <= NAS_FLAG_RST;
    else if (go && st_wr && wb_addr == NAS_ADDR_STATUS_LO)
      bcd_flag_r <= wb_data[NAS_BIT_BCD];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic hi_target; // Write-back aims at the flag nibble
  assign hi_target = st_wr && (wb_addr == NAS_ADDR_STATUS_HI);

  chk_reset_clears: assert property (disable iff (1'b0)
    srst |=> (status_hi == NAS_NIBBLE_ZERO) && (status_lo == NAS_NIBBLE_ZERO))
    else $error("status word not cleared by reset");

  chk_reserved_zero: assert property (
    (status_hi[0] == 1'b0) && (status_lo[3:1] == 3'h0))
    else $error("reserved status bits not zero");

  chk_compare_carry: assert property (
    go && compare |=> $stable(carry_flag_r))
    else $error("compare changed carry");

  chk_zero_set: assert property (
    go && arith && arith_zero && !compare_accumulate_flag_r && !hi_target
    |=> zero_flag_r && status_hi[NAS_BIT_ZERO])
    else $error("zero flag not set on zero result");

  chk_zero_clear: assert property (
    go && arith && !arith_zero && !hi_target |=> !zero_flag_r)
    else $error("zero flag not cleared on non-zero result");

  chk_zero_hold: assert property (
    go && arith && arith_zero && compare_accumulate_flag_r && !hi_target
    |=> zero_flag_r == $past(zero_flag_r))
    else $error("zero flag changed during accumulated match");

  chk_bit_test_clears: assert property (
    go && bit_test |=> !compare_accumulate_flag_r ##0 !status_hi[NAS_BIT_COMPARE])
    else $error("bit test left compare flag set");

  chk_arith_carry: assert property (
    go && arith && compare_accumulate_flag_r && !hi_target
    |=> carry_flag_r == $past(alu.cout))
    else $error("carry not updated while accumulating");

  chk_rotate_result: assert property (
    go && rotate |=> wr_en && (wr_data == {$past(carry_flag_r), $past(gr_rdata[3:1])})
                     && (carry_flag_r == $past(gr_rdata[0])))
    else $error("rotate through carry wrong");

  chk_skip_equal: assert property (
    go && (op == NAS_OP_SKIP_EQUAL) |=> (skip == ($past(mem_val) == $past(imm))) && !wr_en)
    else $error("equal skip wrong or result stored");

  chk_skip_unequal: assert property (
    go && (op == NAS_OP_SKIP_UNEQUAL) |=> skip == ($past(mem_val) != $past(imm)))
    else $error("unequal skip wrong");

  chk_skip_not_less: assert property (
    go && (op == NAS_OP_SKIP_NOT_LESS) |=> skip == ($past(mem_val) >= $past(imm)))
    else $error("not-less skip wrong");

  chk_skip_less: assert property (
    go && (op == NAS_OP_SKIP_LESS) |=> skip == ($past(mem_val) < $past(imm)))
    else $error("less skip wrong");

  chk_bits_set: assert property (
    go && (op == NAS_OP_SKIP_BITS_SET)
    |=> (skip == (($past(mem_val) & $past(imm)) == $past(imm))) && !wr_en)
    else $error("bit set test wrong or result stored");

  chk_bits_clear: assert property (
    go && (op == NAS_OP_SKIP_BITS_CLEAR)
    |=> (skip == (($past(mem_val) & $past(imm)) == NAS_NIBBLE_ZERO)) && !wr_en)
    else $error("bit clear test wrong or result stored");

  chk_carry_binary: assert property (
    go && (op == NAS_OP_ADD_IM) && !bcd_flag_r && !hi_target
    |=> carry_flag_r == ($past({1'b0, mem_val} + {1'b0, imm}) > 5'h0F))
    else $error("binary add carry wrong");

  chk_decimal_write: assert property (
    go && (op == NAS_OP_MOVE_IM) && (mem_addr == NAS_ADDR_STATUS_LO)
    |=> status_lo == {3'h0, $past(imm[0])})
    else $error("decimal flag not written from status word");

  chk_status_held: assert property (
    go && st_wr |=> !wr_en)
    else $error("status write reached data memory");

  chk_gr_target: assert property (
    go && gr_form && wb_en |=> wr_en && (wr_addr == {NAS_GR_ROW, $past(gr_col)}))
    else $error("register result not written to row zero");

  chk_mem_target: assert property (
    go && !gr_form && wb_en && !st_wr |=> wr_en && (wr_addr == $past(mem_addr)))
    else $error("memory result not written to its operand");

  chk_frozen_hold: assert property (
    !clk_en |=> $stable(wr_en) && $stable(skip) && $stable(status_hi) && $stable(status_lo))
    else $error("outputs moved while clock enable low");

endmodule : nas_alu
`default_nettype wire

// ===== hw/nas_alu_if.sv
// Operand and result bundle between the ALU control and its two units.
// Assumes all three ends sit on the same core clock.
`timescale 1ns/100ps
`default_nettype none
interface nas_alu_if;
  logic [3:0] opa;     // First operand
  logic [3:0] opb;     // Second operand
  logic cin;           // Carry or borrow in
  logic sub;           // Subtract when high
  logic dec;           // Decimal digit mode
  logic [1:0] lsel;    // 0 OR, 1 AND, 2 XOR, 3 rotate right
  logic [3:0] sum;     // Adder result
  logic cout;          // Carry or borrow out
  logic [3:0] lres;    // Logic or rotate result
  logic lcout;         // Bit leaving on rotate
  modport ctrl (output opa, opb, cin, sub, dec, lsel, input sum, cout, lres, lcout);
  modport arith (input opa, opb, cin, sub, dec, output sum, cout);
  modport logic_u (input opa, opb, cin, lsel, output lres, lcout);
endinterface : nas_alu_if
`default_nettype wire

// ===== hw/nas_logic.sv
// Logic and rotate unit of the nibble ALU.
// Assumes the carry flag arrives on cin for rotation.
`timescale 1ns/100ps
`default_nettype none
module nas_logic
(
  nas_alu_if.logic_u alu
);
  import nas_pkg::*;

  // ----------------------------------------------------------------
  // Bitwise operations and rotation through carry
  // ----------------------------------------------------------------
  always_comb
  begin
    alu.lcout = alu.opa[0];
    unique case (alu.lsel)
      2'h0: alu.lres = alu.opa | alu.opb;
      2'h1: alu.lres = alu.opa & alu.opb;
      2'h2: alu.lres = alu.opa ^ alu.opb;
      2'h3: alu.lres = {alu.cin, alu.opa[3:1]};
    endcase
  end

endmodule : nas_logic
`default_nettype wire

// ===== hw/nas_pkg.sv
// Shared constants, operation codes and decode helpers of the nibble ALU.
// Assumes a single core clock; every consumer imports nas_pkg::*.
// Summary of operation
// - Status word lives at nibbles 7FH and 7EH
// - Decimal bit0@7EH; compare bit3, carry bit2, zero bit1
// - Unused status bits always read as zero
// - Compare-and-skip leaves carry flag untouched
// - Arithmetic updates carry even with compare flag set
// - Reset clears every status word bit
// - Zero result, compare flag clear: zero flag set
// - Non-zero result clears zero flag unless the result is written to 7FH
// - Compare flag set: zero result holds zero flag
// - Bit tests clear the compare-accumulate flag
// - General register is data memory row zero
// - Flag flip-flops and status word bits are one
// - Every operation finishes in one instruction
// - Add/subtract on register-memory or memory-immediate operands
// - AND, OR, XOR on both operand forms
// - Bit tests check selected bits, store nothing
// - Memory versus immediate: equal, unequal, not-less, less
// - Rotate moves register nibble toward bit zero
// - Rotation passes through the carry flag
// - Compare subtracts, stores nothing, skips per condition
package nas_pkg;

  // ----------------------------------------------------------------
  // Status word placement
  // ----------------------------------------------------------------
  localparam logic [6:0] NAS_ADDR_STATUS_LO = 7'h7E; // Decimal-mode nibble
  localparam logic [6:0] NAS_ADDR_STATUS_HI = 7'h7F; // Flag nibble
  localparam logic [2:0] NAS_GR_ROW = 3'h0;          // Row pointer is fixed
  localparam int NAS_BIT_BCD = 0;
  localparam int NAS_BIT_COMPARE = 3;
  localparam int NAS_BIT_CARRY = 2;
  localparam int NAS_BIT_ZERO = 1;
  localparam logic NAS_FLAG_RST = 1'b0;              // Every flag after reset
  localparam logic [3:0] NAS_NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] NAS_BCD_MAX = 4'h9;         // Largest decimal digit
  localparam logic [3:0] NAS_BCD_ADJ = 4'h6;         // Decimal correction

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    NAS_OP_NOP,
    NAS_OP_ADD_GR, NAS_OP_ADDC_GR, NAS_OP_SUB_GR, NAS_OP_SUBC_GR,
    NAS_OP_ADD_IM, NAS_OP_ADDC_IM, NAS_OP_SUB_IM, NAS_OP_SUBC_IM,
    NAS_OP_OR_GR, NAS_OP_AND_GR, NAS_OP_XOR_GR,
    NAS_OP_OR_IM, NAS_OP_AND_IM, NAS_OP_XOR_IM,
    NAS_OP_SKIP_BITS_SET, NAS_OP_SKIP_BITS_CLEAR,
    NAS_OP_SKIP_EQUAL, NAS_OP_SKIP_UNEQUAL, NAS_OP_SKIP_NOT_LESS, NAS_OP_SKIP_LESS,
    NAS_OP_ROTATE_RIGHT, NAS_OP_MOVE_IM
  } nas_op_e;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic nas_is_arith(input nas_op_e op);
    return op inside {NAS_OP_ADD_GR, NAS_OP_ADDC_GR, NAS_OP_SUB_GR, NAS_OP_SUBC_GR,
                      NAS_OP_ADD_IM, NAS_OP_ADDC_IM, NAS_OP_SUB_IM, NAS_OP_SUBC_IM};
  endfunction : nas_is_arith

  function automatic logic nas_is_logic(input nas_op_e op);
    return op inside {NAS_OP_OR_GR, NAS_OP_AND_GR, NAS_OP_XOR_GR,
                      NAS_OP_OR_IM, NAS_OP_AND_IM, NAS_OP_XOR_IM};
  endfunction : nas_is_logic

  function automatic logic nas_is_compare(input nas_op_e op);
    return op inside {NAS_OP_SKIP_EQUAL, NAS_OP_SKIP_UNEQUAL,
                      NAS_OP_SKIP_NOT_LESS, NAS_OP_SKIP_LESS};
  endfunction : nas_is_compare

  function automatic logic nas_is_bit_test(input nas_op_e op);
    return op inside {NAS_OP_SKIP_BITS_SET, NAS_OP_SKIP_BITS_CLEAR};
  endfunction : nas_is_bit_test

endpackage : nas_pkg
